/* File: design/rfs_core.sv */
// Working register file, index pointers, stack pointer and page register
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "rfs_params.svh"
module rfs_core (
	input wire logic sys_clk,
	input wire logic rst,
	rfs_if.dev bus,
	output logic [15:0] stk_addr,
	output logic stk_we,
	output logic [15:0] stk_wdata,
	output logic [15:0] sp_value,
	output logic [23:0] pm_addr
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [7:0] rf_r [32];
	logic [15:0] sp_r;
	logic [15:0] sp_nxt;
	logic [7:0] page_r;
	logic [7:0] page_nxt;
	logic [7:0] tmp_r;
	logic [7:0] tmp_nxt;
	logic [7:0] rd_a_r;
	logic [7:0] rd_b_r;
	logic [15:0] rd_word_r;
	logic [15:0] ptr_addr_r;
	logic [7:0] io_rdata_r;
	logic io_hit_r;
	logic [15:0] stk_addr_r;
	logic stk_we_r;
	logic [15:0] stk_wdata_r;
	logic [23:0] pm_addr_r;

	// ----------------------------------------------------------------
	// Operation decode
	// ----------------------------------------------------------------
	wire op_wr8 = bus.op == rfs_pkg::OP_WR8;
	wire op_wr16 = bus.op == rfs_pkg::OP_WR16;
	wire op_ptr = bus.op == rfs_pkg::OP_PTR;
	wire op_push = bus.op == rfs_pkg::OP_PUSH;
	wire op_pop = bus.op == rfs_pkg::OP_POP;
	wire op_call = bus.op == rfs_pkg::OP_CALL;
	wire op_ret = bus.op == rfs_pkg::OP_RET;
	wire op_iord = bus.op == rfs_pkg::OP_IORD;
	wire op_iowr = bus.op == rfs_pkg::OP_IOWR;
	wire op_drd = bus.op == rfs_pkg::OP_DRD;
	wire op_dwr = bus.op == rfs_pkg::OP_DWR;

	// ----------------------------------------------------------------
	// Address mapping of data and short I/O accesses
	// ----------------------------------------------------------------
	// Short I/O only spans 64 locations, so anything beyond is refused
	// and the extended range stays data-space only.
	wire io_ok = bus.addr <= `RFS_IO_TOP;
	wire is_io = op_iord | op_iowr;
	wire [15:0] daddr = is_io ? bus.addr + `RFS_IO_OFFSET : bus.addr;
	wire acc_rd = op_drd | (op_iord & io_ok);
	wire acc_wr = op_dwr | (op_iowr & io_ok);
	wire hit_rf = daddr <= `RFS_RF_TOP;
	wire hit_page = daddr == `RFS_ADDR_PAGE;
	wire hit_tmp = daddr == `RFS_ADDR_TMP;
	wire hit_spl = daddr == `RFS_ADDR_SPL;
	wire hit_sph = daddr == `RFS_ADDR_SPH;
	wire hit_any = hit_rf | hit_page | hit_tmp | hit_spl | hit_sph;

	// Read selection; the high stack byte comes from the latched copy
	wire [7:0] rd_mux = hit_rf ? rf_r[daddr[4:0]] :
		hit_page ? page_r :
		hit_tmp ? tmp_r :
		hit_spl ? sp_r[7:0] :
		hit_sph ? tmp_r : 8'h00;

	// ----------------------------------------------------------------
	// Indirect pointers
	// ----------------------------------------------------------------
	// Pair base is even: low byte at base, high byte at base plus one
	wire [4:0] ptr_base = `RFS_PTR_BASE + {2'b00, bus.ptr_sel, 1'b0};
	wire [4:0] ptr_top = {ptr_base[4:1], 1'b1};
	wire [15:0] ptr_cur = {rf_r[ptr_top], rf_r[ptr_base]};
	wire [15:0] ptr_dext = {10'h000, bus.disp};
	wire [15:0] ptr_inc = ptr_cur + 16'h0001;
	wire [15:0] ptr_dec = ptr_cur - 16'h0001;
	wire pm_is_disp = bus.pmode == rfs_pkg::PM_DISP;
	wire pm_is_inc = bus.pmode == rfs_pkg::PM_POSTINC;
	wire pm_is_dec = bus.pmode == rfs_pkg::PM_PREDEC;
	// Effective address; increment uses the old value, decrement the new
	wire [15:0] ptr_eff = pm_is_disp ? ptr_cur + ptr_dext :
		pm_is_dec ? ptr_dec : ptr_cur;
	wire ptr_wb_en = op_ptr & (pm_is_inc | pm_is_dec);
	wire [15:0] ptr_wb = pm_is_inc ? ptr_inc : ptr_dec;

	// ----------------------------------------------------------------
	// Write ports of the register file
	// ----------------------------------------------------------------
	// Byte port serves register writes and data-space stores; word port
	// serves word results and pointer write-back. One op per cycle keeps
	// the two ports from ever aiming at the same entry.
	wire w8_en = op_wr8 | (acc_wr & hit_rf);
	wire [4:0] w8_idx = op_wr8 ? bus.wr_idx : daddr[4:0];
	wire [7:0] w8_dat = bus.wdata[7:0];
	wire w16_en = op_wr16 | ptr_wb_en;
	wire [4:0] w16_idx = op_wr16 ? {bus.wr_idx[4:1], 1'b0} : ptr_base;
	wire [15:0] w16_dat = op_wr16 ? bus.wdata : ptr_wb;

	// One entry per register, each picking its own byte of a port
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : g_rf
			wire hit8 = w8_en && (w8_idx == 5'(gi));
			wire hit16 = w16_en && (w16_idx[4:1] == 4'(gi / 2));
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					rf_r[gi] <= 8'h00;
				end else if (hit8) begin
					rf_r[gi] <= w8_dat;
				end else if (hit16) begin
					rf_r[gi] <= w16_dat[8 * (gi % 2) +: 8];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Stack pointer, temporary byte and page register
	// ----------------------------------------------------------------
	// Downward stack; a high-byte store commits the held low byte too
	assign sp_nxt = op_push ? sp_r - 16'h0001 :
		op_pop ? sp_r + 16'h0001 :
		op_call ? sp_r - 16'h0002 :
		op_ret ? sp_r + 16'h0002 :
		(acc_wr & hit_sph) ? {bus.wdata[7:0], tmp_r} : sp_r;

	// Single temporary used only by the stack pointer pair and its own address
	assign tmp_nxt = (acc_wr & (hit_spl | hit_tmp)) ? bus.wdata[7:0] :
		(acc_rd & hit_spl) ? sp_r[15:8] : tmp_r;

	// Unimplemented page bits are never stored, so they read zero
	assign page_nxt = (acc_wr & hit_page) ?
		(bus.wdata[7:0] & `RFS_PAGE_MASK) : page_r;

	// Top two pointer bits are cleared on every update
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sp_r <= `RFS_SP_RESET;
			tmp_r <= 8'h00;
			page_r <= `RFS_PAGE_RESET;
		end else begin
			sp_r <= sp_nxt & `RFS_SP_MASK;
			tmp_r <= tmp_nxt;
			page_r <= page_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Stack memory request
	// ----------------------------------------------------------------
	// Push and call write at the current top before the pointer moves;
	// pop and return read above it, after the pointer has moved.
	wire stk_down = op_push | op_call;
	wire stk_up = op_pop | op_ret;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stk_addr_r <= 16'h0000;
			stk_we_r <= 1'b0;
			stk_wdata_r <= 16'h0000;
		end else begin
			stk_addr_r <= stk_up ? sp_r + 16'h0001 : sp_r;
			stk_we_r <= stk_down;
			stk_wdata_r <= bus.wdata;
		end
	end

	// ----------------------------------------------------------------
	// Read ports, access results and program address
	// ----------------------------------------------------------------
	// Two byte ports and one word port sampled every cycle
	wire [4:0] word_lo = {bus.rd_a_idx[4:1], 1'b0};
	wire [4:0] word_hi = {bus.rd_a_idx[4:1], 1'b1};
	// Plain program load keeps the page field at zero
	wire [7:0] pm_page = bus.pm_ext ? page_r : 8'h00;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_a_r <= 8'h00;
			rd_b_r <= 8'h00;
			rd_word_r <= 16'h0000;
			ptr_addr_r <= 16'h0000;
			io_rdata_r <= 8'h00;
			io_hit_r <= 1'b0;
			pm_addr_r <= 24'h000000;
		end else begin
			rd_a_r <= rf_r[bus.rd_a_idx];
			rd_b_r <= rf_r[bus.rd_b_idx];
			rd_word_r <= {rf_r[word_hi], rf_r[word_lo]};
			ptr_addr_r <= op_ptr ? ptr_eff : ptr_addr_r;
			io_rdata_r <= acc_rd ? rd_mux : 8'h00;
			io_hit_r <= (acc_rd | acc_wr) & hit_any;
			pm_addr_r <= {pm_page, rf_r[31], rf_r[30]};
		end
	end

	// Outputs straight from registers
	assign bus.rd_a = rd_a_r;
	assign bus.rd_b = rd_b_r;
	assign bus.rd_word = rd_word_r;
	assign bus.ptr_addr = ptr_addr_r;
	assign bus.io_rdata = io_rdata_r;
	assign bus.io_hit = io_hit_r;
	assign stk_addr = stk_addr_r;
	assign stk_we = stk_we_r;
	assign stk_wdata = stk_wdata_r;
	assign sp_value = sp_r;
	assign pm_addr = pm_addr_r;

endmodule
`default_nettype wire

/* File: design/rfs_exec.sv */
// Instruction executor end: Wishbone command registers driving the block
`timescale 1ns/10ps
`default_nettype none
`include "rfs_params.svh"
module rfs_exec (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	rfs_if.exec bus
);

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	logic ack_r;
	logic [31:0] cmd_r;
	logic [31:0] arg_r;
	rfs_pkg::rfs_op_t op_r;
	logic cap_r;
	logic [31:0] res0_r;
	logic [31:0] res1_r;

	// Writes take effect on the edge where the master sees ack
	wire req = cyc_i & stb_i;
	wire wr_go = req & we_i & ack_r;
	wire [1:0] widx = adr_i[3:2];
	wire wr_cmd = wr_go & (widx == `RFS_WB_CMD);
	wire wr_arg = wr_go & (widx == `RFS_WB_ARG);
	wire busy = (op_r != rfs_pkg::OP_NOP) | cap_r;

	// Ack one cycle after the strobe, dropped the cycle after
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end

	// Argument bytes honour the byte selects
	genvar gb;
	generate
		for (gb = 0; gb < 4; gb = gb + 1) begin : g_arg
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					arg_r[8 * gb +: 8] <= 8'h00;
				end else if (wr_arg && sel_i[gb]) begin
					arg_r[8 * gb +: 8] <= dat_i[8 * gb +: 8];
				end
			end
		end
	endgenerate

	// Command write issues its operation for exactly one cycle; the
	// results are captured one cycle later, when the block's flops hold them
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cmd_r <= 32'h00000000;
			op_r <= rfs_pkg::OP_NOP;
			cap_r <= 1'b0;
		end else begin
			cmd_r <= wr_cmd ? dat_i : cmd_r;
			op_r <= wr_cmd ? rfs_pkg::rfs_op_t'(dat_i[3:0]) : rfs_pkg::OP_NOP;
			cap_r <= op_r != rfs_pkg::OP_NOP;
		end
	end

	// Result capture; read ports are resampled after every command except a no-op
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			res0_r <= 32'h00000000;
			res1_r <= 32'h00000000;
		end else if (cap_r) begin
			res0_r <= {7'h00, bus.io_hit, bus.io_rdata, bus.rd_b, bus.rd_a};
			res1_r <= {bus.rd_word, bus.ptr_addr};
		end
	end

	// Read data, zero outside a read cycle; busy shows in the top bit of the first result word
	wire [31:0] rd_sel = (widx == `RFS_WB_CMD) ? cmd_r :
		(widx == `RFS_WB_ARG) ? arg_r :
		(widx == `RFS_WB_RES0) ? {busy, res0_r[30:0]} : res1_r;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dat_o <= 32'h00000000;
		end else begin
			dat_o <= (req & ~we_i & ~ack_r) ? rd_sel : 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// Request fields toward the block
	// ----------------------------------------------------------------
	// Two-byte register sequences are ordered by software: low byte first
	// on write and read, with interrupts masked around the pair.
	assign ack_o = ack_r;
	assign bus.op = op_r;
	assign bus.rd_a_idx = cmd_r[8:4];
	assign bus.rd_b_idx = cmd_r[13:9];
	assign bus.wr_idx = cmd_r[8:4];
	assign bus.ptr_sel = cmd_r[15:14];
	assign bus.pmode = rfs_pkg::rfs_pmode_t'(cmd_r[17:16]);
	assign bus.disp = cmd_r[23:18];
	assign bus.pm_ext = cmd_r[24];
	assign bus.addr = arg_r[15:0];
	assign bus.wdata = arg_r[31:16];

endmodule
`default_nettype wire

/* File: design/rfs_if.sv */
// Interface between instruction executor and register file block
`timescale 1ns/10ps
`default_nettype none
interface rfs_if;
	rfs_pkg::rfs_op_t op;
	logic [4:0] rd_a_idx;
	logic [4:0] rd_b_idx;
	logic [4:0] wr_idx;
	logic [15:0] wdata;
	logic [15:0] addr;
	logic [1:0] ptr_sel;
	rfs_pkg::rfs_pmode_t pmode;
	logic [5:0] disp;
	logic pm_ext;
	logic [7:0] rd_a;
	logic [7:0] rd_b;
	logic [15:0] rd_word;
	logic [15:0] ptr_addr;
	logic [7:0] io_rdata;
	logic io_hit;

	// Register file end
	modport dev (
		input op, rd_a_idx, rd_b_idx, wr_idx, wdata, addr,
		input ptr_sel, pmode, disp, pm_ext,
		output rd_a, rd_b, rd_word, ptr_addr, io_rdata, io_hit
	);

	// Executor end
	modport exec (
		output op, rd_a_idx, rd_b_idx, wr_idx, wdata, addr,
		output ptr_sel, pmode, disp, pm_ext,
		input rd_a, rd_b, rd_word, ptr_addr, io_rdata, io_hit
	);
endinterface
`default_nettype wire

/* File: design/rfs_params.svh */
// Constants for the register file and stack pointer block and its executor
`ifndef RFS_PARAMS_SVH
`define RFS_PARAMS_SVH

// How it works
// - Four read/write port schemes, 8 and 16 bit
// - Working registers mapped at data addresses 0x00-0x1F
// - Top six registers form three low-high pointers
// - Pointers support displacement, post-increment, pre-decrement
// - Stack grows downward; pointer holds top
// - Byte push decrements stack pointer by one
// - Byte pop increments stack pointer by one
// - Calls store return address, pointer minus two
// - Returns fetch return address, pointer plus two
// - Stack pointer resets to 0x10FF
// - Stack pointer bits 15:14 read zero
// - Stack pointer low at 0x5D, high next
// - Short I/O address plus 0x20 gives data address
// - Extended I/O only reachable through data space
// - Extended program address is page above Z
// - Plain program load ignores the page register
// - Unimplemented page bits read zero; write zeros
// - Low byte write held, high write commits both
// - Low byte read latches high into temporary
// - Temporary byte directly readable and writable
// - Software masks interrupts around two-byte accesses
// - Software sets stack pointer before calls

// ----------------------------------------------------------------
// Data space map
// ----------------------------------------------------------------
`define RFS_RF_TOP 16'h001F
`define RFS_IO_OFFSET 16'h0020
`define RFS_IO_TOP 16'h003F
`define RFS_ADDR_PAGE 16'h005B
`define RFS_ADDR_TMP 16'h005C
`define RFS_ADDR_SPL 16'h005D
`define RFS_ADDR_SPH 16'h005E

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define RFS_SP_RESET 16'h10FF
`define RFS_SP_MASK 16'h3FFF
`define RFS_PAGE_RESET 8'h00
`define RFS_PAGE_MASK 8'h01
`define RFS_PTR_BASE 5'h1A

// ----------------------------------------------------------------
// Executor command registers, word index on the Wishbone bus
// ----------------------------------------------------------------
`define RFS_WB_CMD 2'h0
`define RFS_WB_ARG 2'h1
`define RFS_WB_RES0 2'h2
`define RFS_WB_RES1 2'h3

`endif

/* File: design/rfs_pkg.sv */
// Types shared by the register file block and its executor
package rfs_pkg;
	// Operation issued for one cycle by the executor
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_WR8 = 4'h1,
		OP_WR16 = 4'h2,
		OP_PTR = 4'h3,
		OP_PUSH = 4'h4,
		OP_POP = 4'h5,
		OP_CALL = 4'h6,
		OP_RET = 4'h7,
		OP_DRD = 4'h8,
		OP_DWR = 4'h9,
		OP_IORD = 4'hA,
		OP_IOWR = 4'hB
	} rfs_op_t;

	// Indirect pointer addressing modes
	typedef enum logic [1:0] {
		PM_DISP = 2'h0,
		PM_POSTINC = 2'h1,
		PM_PREDEC = 2'h2
	} rfs_pmode_t;
endpackage

/* File: dv/cpu_register_file_and_stack_pointer_test.sv */
// Self-checking bench joining executor and register file ends
`timescale 1ns/10ps
`default_nettype none
module cpu_register_file_and_stack_pointer_test;
	localparam logic [3:0] op_drd = rfs_pkg::OP_DRD;
	localparam logic [3:0] op_dwr = rfs_pkg::OP_DWR;
	localparam logic [3:0] op_iord = rfs_pkg::OP_IORD;
	localparam logic [3:0] op_iowr = rfs_pkg::OP_IOWR;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat_w = 32'h0;
	logic [31:0] dat_r;
	logic ack;
	logic [15:0] stk_addr;
	logic stk_we;
	logic [15:0] stk_wdata;
	logic [15:0] sp_value;
	logic [23:0] pm_addr;
	logic [31:0] r0;
	logic [31:0] r1;
	logic [31:0] rdat;
	int bad_count = 0;
	int checks_done = 0;
	rfs_if rif ();

	// Free-running 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	rfs_core rfs_core_i (.sys_clk(sys_clk), .rst(rst), .bus(rif.dev),
		.stk_addr(stk_addr), .stk_we(stk_we), .stk_wdata(stk_wdata),
		.sp_value(sp_value), .pm_addr(pm_addr));
	// Byte selects come from the bus master with the rest of the request
	rfs_exec rfs_exec_i (.sys_clk(sys_clk), .rst(rst), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w),
		.dat_o(dat_r), .ack_o(ack), .bus(rif.exec));
	rfs_checker rfs_checker_i (.sys_clk(sys_clk), .rst(rst), .op(rif.op),
		.wdata(rif.wdata), .addr(rif.addr), .pm_ext(rif.pm_ext),
		.ptr_addr(rif.ptr_addr), .io_hit(rif.io_hit), .stk_addr(stk_addr),
		.stk_we(stk_we), .stk_wdata(stk_wdata), .sp_value(sp_value),
		.pm_addr(pm_addr));

	// ------------------------------------------------
	// Bus tasks
	// ------------------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Classic cycle held until ack is sampled; bounded wait
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		dat_w <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			final_report();
		end
		rdat = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// Argument, command, then both result words once busy clears
	task automatic run(input logic [3:0] o, input logic [4:0] ia,
		input logic [4:0] ib, input logic [1:0] ps, input logic [1:0] pm,
		input logic [5:0] dp, input logic ex, input logic [15:0] ad,
		input logic [15:0] wd);
		int n;
		n = 0;
		wb(1'b1, 4'h4, {wd, ad});
		wb(1'b1, 4'h0, {7'h00, ex, dp, pm, ps, ib, ia, o});
		do begin
			wb(1'b0, 4'h8, 32'h0);
			n++;
		end while (rdat[31] !== 1'b0 && n < 10);
		if (n >= 10) begin
			bad_count++;
			final_report();
		end
		r0 = rdat;
		wb(1'b0, 4'hC, 32'h0);
		r1 = rdat;
	endtask

	task automatic acc(input logic [3:0] o, input logic [15:0] ad,
		input logic [15:0] wd);
		run(o, 5'h00, 5'h00, 2'h0, 2'h0, 6'h00, 1'b0, ad, wd);
	endtask

	// A no-op command captures no results, so a harmless read of
	// register 0 is issued instead to resample the read ports
	task automatic nop(input logic [4:0] ia, input logic ex);
		run(op_drd, ia, 5'h1B, 2'h0, 2'h0, 6'h00, ex, 16'h0, 16'h0);
	endtask

	// Pointer op on the first pair, then a read-back of the pair
	task automatic pstep(input logic [1:0] pm, input logic [5:0] dp,
		input logic [15:0] ep, input logic [15:0] ew);
		run(rfs_pkg::OP_PTR, 5'h1A, 5'h00, 2'h0, pm, dp, 1'b0, 16'h0, 16'h0);
		chk(r1[15:0], ep);
		nop(5'h1A, 1'b0);
		chk(r1[31:16], ew);
	endtask

	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		chk(sp_value, 16'h10FF);
		acc(op_drd, 16'h005D, 16'h0);
		chk(r0[24:16], 9'h1FF);
		acc(op_drd, 16'h005E, 16'h0);
		chk(r0[24:16], 9'h110);
		acc(op_iord, 16'h003D, 16'h0);
		chk(r0[24:16], 9'h1FF);
		// Low byte waits in the shared byte until the high write
		acc(op_dwr, 16'h005D, 16'h0034);
		chk(sp_value, 16'h10FF);
		acc(op_dwr, 16'h005E, 16'h00F2);
		chk(sp_value, 16'h3234);
		acc(op_dwr, 16'h005C, 16'h005A);
		acc(op_drd, 16'h005C, 16'h0);
		chk(r0[23:16], 8'h5A);
		// High byte read returns the copy even after a push moves it
		acc(op_iowr, 16'h003D, 16'h0000);
		acc(op_iowr, 16'h003E, 16'h0001);
		chk(sp_value, 16'h0100);
		acc(op_drd, 16'h005D, 16'h0);
		chk(r0[23:16], 8'h00);
		acc(rfs_pkg::OP_PUSH, 16'h0, 16'h00AA);
		chk(sp_value, 16'h00FF);
		acc(op_drd, 16'h005C, 16'h0);
		chk(r0[23:16], 8'h01);
		acc(op_drd, 16'h005E, 16'h0);
		chk(r0[23:16], 8'h01);
		acc(rfs_pkg::OP_POP, 16'h0, 16'h0);
		chk(sp_value, 16'h0100);
		acc(rfs_pkg::OP_CALL, 16'h0, 16'h1234);
		chk(sp_value, 16'h00FE);
		acc(rfs_pkg::OP_RET, 16'h0, 16'h0);
		chk(sp_value, 16'h0100);
		// Register file by port and by data address
		run(rfs_pkg::OP_WR8, 5'h05, 5'h00, 2'h0, 2'h0, 6'h00, 1'b0,
			16'h0, 16'h00A5);
		acc(op_dwr, 16'h0006, 16'h003C);
		run(op_drd, 5'h06, 5'h05, 2'h0, 2'h0, 6'h00, 1'b0, 16'h0005, 16'h0);
		chk(r0[24:0], 25'h1A5A53C);
		run(rfs_pkg::OP_WR16, 5'h1A, 5'h00, 2'h0, 2'h0, 6'h00, 1'b0,
			16'h0, 16'h1234);
		nop(5'h1A, 1'b0);
		chk(r0[15:0], 16'h1234);
		chk(r1[31:16], 16'h1234);
		pstep(rfs_pkg::PM_POSTINC, 6'h00, 16'h1234, 16'h1235);
		pstep(rfs_pkg::PM_PREDEC, 6'h00, 16'h1234, 16'h1234);
		pstep(rfs_pkg::PM_DISP, 6'h05, 16'h1239, 16'h1234);
		// Page register sits above Z only for the extended load
		run(rfs_pkg::OP_WR16, 5'h1E, 5'h00, 2'h0, 2'h0, 6'h00, 1'b0,
			16'h0, 16'hBEEF);
		acc(op_dwr, 16'h005B, 16'h00FF);
		acc(op_drd, 16'h005B, 16'h0);
		chk(r0[23:16], 8'h01);
		nop(5'h1E, 1'b1);
		chk(pm_addr, 24'h01BEEF);
		nop(5'h1E, 1'b0);
		chk(pm_addr, 24'h00BEEF);
		// I/O commands stop at the short window
		acc(op_iowr, 16'h005D, 16'h0055);
		chk({r0[24], sp_value}, 17'h00100);
		acc(op_iord, 16'h0060, 16'h0);
		chk(r0[24:16], 9'h000);
		// Second reset in mid-run
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		chk(sp_value, 16'h10FF);
		acc(op_drd, 16'h005B, 16'h0);
		chk(r0[24:16], 9'h100);
		final_report();
	end
endmodule
`default_nettype wire

/* File: dv/rfs_checker.sv */
// Concurrent checks on the executor to register file link
`timescale 1ns/10ps
`default_nettype none
`include "rfs_params.svh"
module rfs_checker (
	input wire logic sys_clk,
	input wire logic rst,
	input wire rfs_pkg::rfs_op_t op,
	input wire logic [15:0] wdata,
	input wire logic [15:0] addr,
	input wire logic pm_ext,
	input wire logic [15:0] ptr_addr,
	input wire logic io_hit,
	input wire logic [15:0] stk_addr,
	input wire logic stk_we,
	input wire logic [15:0] stk_wdata,
	input wire logic [15:0] sp_value,
	input wire logic [23:0] pm_addr
);
	// ------------------------------------------------
	// Stack pointer and stack port checks
	// ------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	push_dec_a: assert property (op == rfs_pkg::OP_PUSH |=>
		sp_value == (($past(sp_value) - 16'h0001) & `RFS_SP_MASK))
		else $error("push did not lower the pointer by one");
	pop_inc_a: assert property (op == rfs_pkg::OP_POP |=>
		sp_value == (($past(sp_value) + 16'h0001) & `RFS_SP_MASK))
		else $error("pop did not raise the pointer by one");
	call_dec_a: assert property (op == rfs_pkg::OP_CALL |=>
		sp_value == (($past(sp_value) - 16'h0002) & `RFS_SP_MASK))
		else $error("call did not lower the pointer by two");
	ret_inc_a: assert property (op == rfs_pkg::OP_RET |=>
		sp_value == (($past(sp_value) + 16'h0002) & `RFS_SP_MASK))
		else $error("return did not raise the pointer by two");
	sp_top_zero_a: assert property (sp_value[15:14] == 2'h0)
		else $error("stack pointer top bits not zero");
	// Data lands at the old top before the pointer moves
	stack_write_a: assert property (
		op inside {rfs_pkg::OP_PUSH, rfs_pkg::OP_CALL} |=> stk_we &&
		stk_addr == $past(sp_value) && stk_wdata == $past(wdata))
		else $error("push or call wrote the wrong place");
	pop_addr_a: assert property (
		op inside {rfs_pkg::OP_POP, rfs_pkg::OP_RET} |=>
		!stk_we && stk_addr == $past(sp_value) + 16'h0001)
		else $error("pop read the wrong place");
	we_cause_a: assert property (stk_we |->
		$past(op) inside {rfs_pkg::OP_PUSH, rfs_pkg::OP_CALL})
		else $error("stack write without push or call");
	sp_hold_a: assert property (!(op inside {rfs_pkg::OP_PUSH,
		rfs_pkg::OP_POP, rfs_pkg::OP_CALL, rfs_pkg::OP_RET,
		rfs_pkg::OP_DWR, rfs_pkg::OP_IOWR}) |=> $stable(sp_value))
		else $error("stack pointer moved by itself");
	// I/O writes never reach past the short window
	io_range_a: assert property (
		op == rfs_pkg::OP_IOWR && addr > `RFS_IO_TOP |=>
		!io_hit && $stable(sp_value))
		else $error("I/O write reached extended range");
	// ------------------------------------------------
	// Pointer and program address checks
	// ------------------------------------------------
	ptr_hold_a: assert property (
		op != rfs_pkg::OP_PTR |=> $stable(ptr_addr))
		else $error("pointer address moved without pointer op");
	plain_load_a: assert property (!pm_ext |=>
		pm_addr[23:16] == 8'h00)
		else $error("page used by plain program load");
	page_bits_a: assert property (pm_addr[23:17] == 7'h00)
		else $error("unimplemented page bits not zero");
endmodule
`default_nettype wire
